/* cardiac_event_model.sv */
// Behavioural far side: cardiac sensing and pulse timing strobes
`timescale 1ns/100ps
module cardiac_event_model (
  // Clock
  input wire logic clk,
  // Cycle strobes toward the governor
  output logic cycle_end,
  output logic atr_sense,
  output logic atr_pace,
  output logic atr_prem,
  output logic vent_sense
);
  // Quiet at start, so no cycle ends during reset
  initial
  begin
    cycle_end = 1'b0;
    atr_sense = 1'b0;
    atr_pace = 1'b0;
    atr_prem = 1'b0;
    vent_sense = 1'b0;
  end

  // One cardiac cycle: strobes last one clock, then a quiet gap
  // Kind 0 paced, 1 atrial sense, 2 atrial pace, 3 premature
  task beat(input logic [1:0] kind);
    @(posedge clk);
    cycle_end <= 1'b1;
    atr_sense <= (kind == 2'h1);
    atr_pace <= (kind == 2'h2);
    atr_prem <= (kind == 2'h3);
    vent_sense <= (kind == 2'h1);
    @(posedge clk);
    cycle_end <= 1'b0;
    atr_sense <= 1'b0;
    atr_pace <= 1'b0;
    atr_prem <= 1'b0;
    vent_sense <= 1'b0;
    // Gap lets the registered outputs settle before checks
    repeat (3) @(posedge clk);
  endtask : beat
endmodule : cardiac_event_model

/* pacing_rate_fading_control.sv */
// Pacing rate fading, smoothing, stabilization and sensor rate governor
`timescale 1ns/100ps
`include "rate_fading_consts.svh"
module pacing_rate_fading_control #(
  parameter int unsigned SEC_CYCLES = 50000000,
  parameter int unsigned DAY_SECONDS = 86400
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Avalon-MM slave
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Cardiac events as one-cycle pulses, then rate, mode switch and sensor levels, all from same-clock logic
  input wire logic CYCLE_END,
  input wire logic ATRIAL_SENSE_EVENT,
  input wire logic ATRIAL_PACE_EVENT,
  input wire logic ATRIAL_PREMATURE,
  input wire logic VENT_SENSE,
  input wire logic [10:0] ATRIAL_RATE,
  input wire logic [10:0] HEART_RATE,
  input wire logic MODE_SWITCH,
  input wire logic [7:0] SENSOR_AMPL,
  // Outputs
  output logic [10:0] PACING_RATE,
  output logic [10:0] SENSOR_RATE_REC
);
  // Registers written by software
  logic [15:0] ctrl_q;
  rate_fading_pkg::rate_t basic_q;
  rate_fading_pkg::rate_t night_q;
  rate_fading_pkg::rate_t msr_q;
  logic [3:0] gain_q;
  logic [3:0] thr_q;
  // Internal governor state
  rate_fading_pkg::rate_t backup_q;
  rate_fading_pkg::rate_t target_q;
  rate_fading_pkg::rate_t sensor_q;
  logic [2:0] as_run_q;
  logic [2:0] fast_run_q;
  logic [2:0] sense_run_q;
  logic stab_armed_q;
  logic follow_q;
  logic ms_stab_q;
  logic ms_d1_q;
  // Daily gain bookkeeping
  logic [31:0] sec_cnt_q;
  logic [31:0] day_sec_q;
  logic [31:0] high_sec_q;
  logic [2:0] days_low_q;
  logic rd_pend_q;

  // Decode of the decrease step to 0.1 bpm units
  function automatic rate_fading_pkg::rate_t dec_units(
    input rate_fading_pkg::dec_step_t s);
    unique case (s)
      rate_fading_pkg::DEC_01: dec_units = 11'h001;
      rate_fading_pkg::DEC_02: dec_units = 11'h002;
      rate_fading_pkg::DEC_05: dec_units = 11'h005;
      rate_fading_pkg::DEC_10: dec_units = 11'h00A;
    endcase
  endfunction : dec_units

  // Slew a rate toward a goal within step limits
  function automatic rate_fading_pkg::rate_t slew(
    input rate_fading_pkg::rate_t cur,
    input rate_fading_pkg::rate_t goal,
    input rate_fading_pkg::rate_t up,
    input rate_fading_pkg::rate_t dn);
    if (goal > cur)
      slew = (goal - cur > up) ? 11'(cur + up) : goal;
    else
      slew = (cur - goal > dn) ? 11'(cur - dn) : goal;
  endfunction : slew

  // Step limits; increase field clamped to 1..10 bpm
  logic [3:0] inc_f;
  rate_fading_pkg::rate_t up_step;
  rate_fading_pkg::rate_t dn_step;
  rate_fading_pkg::rate_t base_rate;
  logic ra_on;
  always_comb
  begin
    inc_f = ctrl_q[`RF_CTRL_INC_LO +: 4];
    if (inc_f == 4'h0)
      inc_f = 4'h1;
    else if (inc_f > 4'hA)
      inc_f = 4'hA;
    up_step = 11'(inc_f) * 11'h00A;
    dn_step = dec_units(rate_fading_pkg::dec_step_t'(
      ctrl_q[`RF_CTRL_DEC_LO +: 2]));
    ra_on = ctrl_q[`RF_CTRL_RA];
  end

  // Night selects the lower basic rate
  always_comb
  begin
    base_rate = ctrl_q[`RF_CTRL_NIGHT] ? night_q : basic_q;
  end

  // Sensor goal: threshold, gain and clamp
  logic [3:0] thr_eff;
  logic [11:0] above;
  logic [15:0] scaled;
  rate_fading_pkg::rate_t sens_goal;
  always_comb
  begin
    thr_eff = thr_q;
    if (ctrl_q[`RF_CTRL_NIGHT] && ra_on && thr_q != `RF_THR_MAX)
      thr_eff = 4'(thr_q + 4'h1);
    above = 12'h000;
    if (SENSOR_AMPL > {thr_eff, 4'h0})
      above = 12'(SENSOR_AMPL - {thr_eff, 4'h0});
    scaled = 16'(above * gain_q);
    if (16'(basic_q) + scaled >= 16'(msr_q))
      sens_goal = msr_q;
    else
      sens_goal = 11'(16'(basic_q) + scaled);
  end

  // Rate used as target fallback: sensor when adaptive and above the base rate
  rate_fading_pkg::rate_t fallback;
  always_comb
  begin
    fallback = (ra_on && sensor_q > base_rate) ? sensor_q : base_rate;
  end

  // Sensor rate slews once per cycle, always computed
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      sensor_q <= `RF_BASIC_RST;
    else if (CYCLE_END)
      sensor_q <= slew(sensor_q, sens_goal, up_step, dn_step);
  end

  // Recorded sensor response, even in non-adaptive modes
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      SENSOR_RATE_REC <= `RF_BASIC_RST;
    else
      SENSOR_RATE_REC <= sensor_q;
  end

  // Atrial sense run and target rate selection
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      as_run_q <= 3'h0;
      target_q <= `RF_BASIC_RST;
    end
    else if (ATRIAL_PREMATURE || ATRIAL_PACE_EVENT)
    begin
      as_run_q <= 3'h0;
      target_q <= fallback;
    end
    else if (MODE_SWITCH)
      target_q <= fallback;
    else if (ATRIAL_SENSE_EVENT)
    begin
      if (as_run_q != `RF_RUN_LEN)
        as_run_q <= 3'(as_run_q + 3'h1);
      if (as_run_q >= 3'(`RF_RUN_LEN - 3'h1))
      begin
        // Four senses seen; clamp so the subtraction cannot wrap
        if (ATRIAL_RATE > `RF_OFFSET_10BPM)
          target_q <= 11'(ATRIAL_RATE - `RF_OFFSET_10BPM);
        else
          target_q <= 11'h000;
      end
    end
  end

  // Next backup value; pacing reads it so both move on one edge
  rate_fading_pkg::rate_t backup_d;
  always_comb
  begin
    backup_d = slew(backup_q, target_q, up_step, dn_step);
  end

  // Backup rate always runs in the background
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      backup_q <= `RF_BASIC_RST;
    else if (CYCLE_END)
      backup_q <= backup_d;
  end

  // Mode switch stabilization needs prior enable
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      ms_stab_q <= 1'b0;
      ms_d1_q <= 1'b0;
    end
    else
    begin
      ms_d1_q <= MODE_SWITCH;
      if (MODE_SWITCH && !ms_d1_q)
        ms_stab_q <= ctrl_q[`RF_CTRL_STAB];
      else if (!MODE_SWITCH)
        ms_stab_q <= 1'b0;
    end
  end

  // Run of sensed cycles arms stabilization
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      sense_run_q <= 3'h0;
      stab_armed_q <= 1'b0;
    end
    else if (CYCLE_END)
    begin
      if (!VENT_SENSE)
        sense_run_q <= 3'h0;
      else if (sense_run_q != `RF_RUN_LEN)
        sense_run_q <= 3'(sense_run_q + 3'h1);
      if (VENT_SENSE && sense_run_q >= 3'(`RF_RUN_LEN - 3'h1))
        stab_armed_q <= 1'b1;
      else if (!ms_stab_q)
        stab_armed_q <= 1'b0;
    end
  end

  // Realignment after four faster intrinsic cycles
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      fast_run_q <= 3'h0;
      follow_q <= 1'b1;
    end
    else if (CYCLE_END)
    begin
      if (VENT_SENSE && HEART_RATE > PACING_RATE)
      begin
        if (fast_run_q != `RF_RUN_LEN)
          fast_run_q <= 3'(fast_run_q + 3'h1);
        if (fast_run_q >= 3'(`RF_RUN_LEN - 3'h1))
          follow_q <= 1'b1;
      end
      else
      begin
        fast_run_q <= 3'h0;
        if (HEART_RATE < PACING_RATE)
          follow_q <= 1'b0;
      end
    end
  end

  // Pacing rate per cycle: jumps while fading, else slewed toward its source
  rate_fading_pkg::rate_t pace_goal;
  always_comb
  begin
    // Armed run only counts when stabilization was enabled
    if (ms_stab_q
      || (MODE_SWITCH && stab_armed_q && ctrl_q[`RF_CTRL_STAB]))
      pace_goal = backup_d;
    else if (!follow_q)
      pace_goal = (backup_d > fallback) ? backup_d : fallback;
    else if (ra_on && sensor_q > base_rate)
      pace_goal = sensor_q;
    else
      pace_goal = base_rate;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      PACING_RATE <= `RF_BASIC_RST;
    else if (CYCLE_END)
      // Fading takes the goal at once; while following, even backup moves slew
      PACING_RATE <= (!follow_q) ? pace_goal :
        slew(PACING_RATE, pace_goal, up_step, dn_step);
  end

  // One-second tick and daily high-rate accumulation
  logic sec_tick;
  logic day_tick;
  logic high_now;
  always_comb
  begin
    sec_tick = (sec_cnt_q == 32'(SEC_CYCLES - 1));
    day_tick = sec_tick && (day_sec_q == 32'(DAY_SECONDS - 1));
    // Fifteen bits so a full-scale rate times ten cannot wrap
    high_now = (15'(sensor_q) * 15'h000A) >= (15'(msr_q) * 15'h0009);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      sec_cnt_q <= 32'h0;
      day_sec_q <= 32'h0;
      high_sec_q <= 32'h0;
    end
    else
    begin
      sec_cnt_q <= sec_tick ? 32'h0 : 32'(sec_cnt_q + 32'h1);
      if (sec_tick)
      begin
        day_sec_q <= day_tick ? 32'h0 : 32'(day_sec_q + 32'h1);
        if (day_tick)
          high_sec_q <= 32'h0;
        else if (high_now && high_sec_q != 32'hFFFFFFFF)
          high_sec_q <= 32'(high_sec_q + 32'h1);
      end
    end
  end

  // Register writes, daily gain adjust, week count
  logic wr;
  always_comb
  begin
    // Write lands at the edge that answers it
    wr = AVS_WRITE && !AVS_WAITREQUEST;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_q <= {4'h0, `RF_INC_RST, 8'h00};
      basic_q <= `RF_BASIC_RST;
      night_q <= `RF_NIGHT_RST;
      msr_q <= `RF_MSR_RST;
      gain_q <= `RF_GAIN_RST;
      thr_q <= `RF_THR_RST;
      days_low_q <= 3'h0;
    end
    else
    begin
      if (wr && AVS_ADDRESS == `RF_CTRL_OFS)
        ctrl_q <= AVS_WRITEDATA[15:0];
      if (wr && AVS_ADDRESS == `RF_RATES_OFS)
      begin
        basic_q <= AVS_WRITEDATA[10:0];
        msr_q <= AVS_WRITEDATA[26:16];
      end
      if (wr && AVS_ADDRESS == `RF_NIGHT_OFS)
        night_q <= AVS_WRITEDATA[10:0];
      // Hardware gain step wins over a software write
      if (day_tick && ctrl_q[`RF_CTRL_AG])
      begin
        if (high_sec_q >= `RF_HIGH_SECONDS)
        begin
          days_low_q <= 3'h0;
          if (gain_q != 4'h0)
            gain_q <= 4'(gain_q - 4'h1);
        end
        else if (days_low_q == 3'(`RF_WEEK_DAYS - 3'h1))
        begin
          days_low_q <= 3'h0;
          if (gain_q != `RF_GAIN_MAX)
            gain_q <= 4'(gain_q + 4'h1);
        end
        else
          days_low_q <= 3'(days_low_q + 3'h1);
      end
      else if (wr && AVS_ADDRESS == `RF_SENS_OFS)
      begin
        gain_q <= AVS_WRITEDATA[3:0];
        thr_q <= AVS_WRITEDATA[7:4];
      end
    end
  end

  // Bus handshake: every access answers in two cycles
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      AVS_WAITREQUEST <= 1'b1;
      rd_pend_q <= 1'b0;
      AVS_READDATA <= 32'h0;
    end
    else
    begin
      rd_pend_q <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && !rd_pend_q)
      begin
        rd_pend_q <= 1'b1;
        AVS_WAITREQUEST <= 1'b0;
        unique case (AVS_ADDRESS)
          `RF_CTRL_OFS: AVS_READDATA <= {5'h0, PACING_RATE, ctrl_q};
          `RF_RATES_OFS: AVS_READDATA <= {5'h0, msr_q, 5'h0, basic_q};
          `RF_SENS_OFS: AVS_READDATA <= {5'h0, backup_q, 5'h0,
            days_low_q, thr_q, gain_q};
          `RF_NIGHT_OFS: AVS_READDATA <= {5'h0, target_q, 5'h0, night_q};
          default: AVS_READDATA <= 32'h0;
        endcase
      end
    end
  end

  // Assertions
  rate_fading_pkg::rate_t pr_prev;
  always_ff @(posedge SYS_CLK)
  begin
    pr_prev <= PACING_RATE;
  end

  sensor_clamp_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    sensor_q <= msr_q || $changed(msr_q) || $past(CYCLE_END) == 1'b0
      || $past(sensor_q) > msr_q)
    else $error("Sensor rate above maximum");
  backup_up_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CYCLE_END && !wr |=> backup_q <= 11'($past(backup_q) + up_step))
    else $error("Backup rose too fast");
  backup_dn_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CYCLE_END && !wr && backup_q >= dn_step
      |=> backup_q >= 11'($past(backup_q) - $past(dn_step)))
    else $error("Backup fell too fast");
  target_base_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ATRIAL_PACE_EVENT |=> target_q == $past(fallback))
    else $error("Paced atrial did not reset target");
  target_atr_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ATRIAL_SENSE_EVENT && !ATRIAL_PREMATURE && !ATRIAL_PACE_EVENT
      && !MODE_SWITCH && as_run_q == 3'h4 && ATRIAL_RATE > 11'h064
      |=> target_q == 11'($past(ATRIAL_RATE) - 11'h064))
    else $error("Target not atrial minus 10");
  thr_ignore_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SENSOR_AMPL <= {thr_eff, 4'h0} |-> sens_goal == basic_q
      || basic_q >= msr_q)
    else $error("Sub-threshold amplitude moved rate");
  stab_gate_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(MODE_SWITCH) && !ctrl_q[2] |=> !ms_stab_q)
    else $error("Stabilization without enable");
  realign_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(follow_q) |-> $past(fast_run_q) == 3'h3
      || $past(fast_run_q) == 3'h4)
    else $error("Realign before four fast cycles");
  hold_pace_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !$past(CYCLE_END) |-> PACING_RATE == pr_prev)
    else $error("Pacing rate moved off cycle");

  cov_fading_c: cover property (@(posedge SYS_CLK) $fell(follow_q));
  cov_gain_dn_c: cover property (@(posedge SYS_CLK)
    day_tick && high_sec_q >= `RF_HIGH_SECONDS);
  cov_ms_c: cover property (@(posedge SYS_CLK) $rose(ms_stab_q));
  cov_clamp_c: cover property (@(posedge SYS_CLK) sens_goal == msr_q);
endmodule : pacing_rate_fading_control

/* pacing_rate_fading_control_tb.sv */
// Self-checking bench for the pacing rate fading governor
`timescale 1ns/100ps
module pacing_rate_fading_control_tb;
  // Clock, reset and bus
  logic clk = 1'b0;
  logic sys_rst;
  logic [3:0] address;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic waitreq;
  // Cardiac strobes and levels
  logic cyc;
  logic a_s;
  logic a_p;
  logic a_pr;
  logic v_s;
  logic [10:0] atr_rate;
  logic [10:0] heart_rate;
  logic mode_sw;
  logic [7:0] ampl;
  logic [10:0] pace;
  logic [10:0] rec;
  // Bookkeeping
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int i;
  logic [31:0] r;
  logic [10:0] b0;
  logic [10:0] b1;
  logic [10:0] dec_tab [4] = '{11'h001, 11'h002, 11'h005, 11'h00A};

  always #10 clk = ~clk;

  // Short counts so a simulated day is 800 clocks
  pacing_rate_fading_control #(.SEC_CYCLES(4), .DAY_SECONDS(200))
    pacing_rate_fading_control_i (.SYS_CLK(clk), .SYS_RST(sys_rst),
    .AVS_ADDRESS(address), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .CYCLE_END(cyc),
    .ATRIAL_SENSE_EVENT(a_s), .ATRIAL_PACE_EVENT(a_p),
    .ATRIAL_PREMATURE(a_pr), .VENT_SENSE(v_s), .ATRIAL_RATE(atr_rate),
    .HEART_RATE(heart_rate), .MODE_SWITCH(mode_sw), .SENSOR_AMPL(ampl),
    .PACING_RATE(pace), .SENSOR_RATE_REC(rec));

  cardiac_event_model cardiac_event_model_i (.clk(clk), .cycle_end(cyc),
    .atr_sense(a_s), .atr_pace(a_p), .atr_prem(a_pr), .vent_sense(v_s));

  // Verdict and end of run
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // Hang guard: the auto gain weeks need about 6400 clocks
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end

  // Compare and count
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task note(input string s);
    $display("test %s done", s);
  endtask : note

  // Avalon write: hold until waitrequest is sampled low
  task bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    while (waitreq !== 1'b0)
      @(posedge clk);
    wr <= 1'b0;
  endtask : bus_write

  // Avalon read: data taken at the edge that sees waitrequest low
  task bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    rd <= 1'b1;
    @(posedge clk);
    while (waitreq !== 1'b0)
      @(posedge clk);
    d = rdata;
    rd <= 1'b0;
  endtask : bus_read

  // Upper rate field of a register
  task get_field(input logic [3:0] a, output logic [10:0] f);
    logic [31:0] t;
    bus_read(a, t);
    f = t[26:16];
  endtask : get_field

  function logic [31:0] ctrl(input logic ra, input logic ag,
    input logic night, input logic [1:0] dec, input logic [3:0] inc);
    return {20'h0, inc, 2'h0, dec, night, 1'b0, ag, ra};
  endfunction : ctrl

  // Expected upward slew, stopping at the goal
  function logic [10:0] up(input logic [10:0] cur, input logic [10:0] goal,
    input logic [10:0] st);
    return (cur + st > goal) ? goal : cur + st;
  endfunction : up

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    address = 4'h0;
    wdata = 32'h0;
    atr_rate = 11'h384;
    heart_rate = 11'h5DC;
    mode_sw = 1'b0;
    ampl = 8'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    check(pace, 32'h258);
    check(rec, 32'h258);
    bus_read(4'h4, r);
    check(r & 32'h07FF07FF, 32'h05140258);
    bus_read(4'h8, r);
    check(r[7:0], 32'h24);
    bus_read(4'h2, r);
    check(r, 32'h0);
    note("reset");
    // Sensor path with adaptation on, fastest steps
    bus_write(4'h0, ctrl(1'b1, 1'b0, 1'b0, 2'h3, 4'hA));
    ampl <= 8'h1F;
    cardiac_event_model_i.beat(2'h0);
    check(rec, 32'h258);
    ampl <= 8'h21;
    cardiac_event_model_i.beat(2'h0);
    check(rec, 32'h25C);
    ampl <= 8'hFF;
    b0 = 11'h25C;
    for (i = 0; i < 8; i++)
    begin
      cardiac_event_model_i.beat(2'h0);
      b0 = up(b0, 11'h514, 11'h064);
      check(rec, b0);
    end
    // Non-adaptive: response still recorded and still slewed
    bus_write(4'h0, ctrl(1'b0, 1'b0, 1'b0, 2'h3, 4'hA));
    ampl <= 8'h00;
    cardiac_event_model_i.beat(2'h0);
    check(rec, 32'h50A);
    note("sensor");
    // Atrial runs set the target; fewer than four are ignored
    bus_write(4'h0, ctrl(1'b0, 1'b0, 1'b0, 2'h3, 4'h2));
    cardiac_event_model_i.beat(2'h2);
    for (i = 0; i < 3; i++)
      cardiac_event_model_i.beat(2'h1);
    get_field(4'hC, b0);
    check(b0, 32'h258);
    cardiac_event_model_i.beat(2'h1);
    get_field(4'hC, b0);
    check(b0, 32'h320);
    get_field(4'h8, b0);
    cardiac_event_model_i.beat(2'h1);
    get_field(4'h8, b1);
    check(b1, up(b0, 11'h320, 11'h014));
    // Increase setting above ten is held at ten
    bus_write(4'h0, ctrl(1'b0, 1'b0, 1'b0, 2'h3, 4'hF));
    atr_rate <= 11'h514;
    cardiac_event_model_i.beat(2'h1);
    get_field(4'h8, b0);
    cardiac_event_model_i.beat(2'h1);
    get_field(4'h8, b1);
    check(b1, up(b0, 11'h4B0, 11'h064));
    // Premature and paced atrial events return to basic
    cardiac_event_model_i.beat(2'h3);
    get_field(4'hC, b0);
    check(b0, 32'h258);
    cardiac_event_model_i.beat(2'h2);
    get_field(4'hC, b0);
    check(b0, 32'h258);
    for (i = 0; i < 4; i++)
    begin
      bus_write(4'h0, ctrl(1'b0, 1'b0, 1'b0, i[1:0], 4'hA));
      get_field(4'h8, b0);
      cardiac_event_model_i.beat(2'h0);
      get_field(4'h8, b1);
      check(b1, b0 - dec_tab[i]);
    end
    note("fading");
    // Sudden drop: pacing takes the backup rate at once
    heart_rate <= 11'h000;
    repeat (2) cardiac_event_model_i.beat(2'h0);
    get_field(4'h8, b0);
    check(pace, b0);
    // Fast intrinsic cycles: three keep backup, the fourth realigns
    heart_rate <= 11'h7D0;
    repeat (3) cardiac_event_model_i.beat(2'h1);
    get_field(4'h8, b0);
    check(pace, b0);
    cardiac_event_model_i.beat(2'h1);
    b0 = pace;
    cardiac_event_model_i.beat(2'h1);
    check(pace, b0 - 11'h00A);
    note("drop");
    // Mode switch without stabilization: target moves, pacing slews
    b1 = pace;
    mode_sw <= 1'b1;
    cardiac_event_model_i.beat(2'h0);
    check(pace, b1 - 11'h00A);
    get_field(4'hC, b0);
    check(b0, 32'h258);
    mode_sw <= 1'b0;
    // Stabilization enabled first: pacing joins the backup rate
    bus_write(4'h0, ctrl(1'b0, 1'b0, 1'b0, 2'h3, 4'hA) | 32'h4);
    mode_sw <= 1'b1;
    repeat (4) cardiac_event_model_i.beat(2'h0);
    get_field(4'h8, b0);
    get_field(4'h0, b1);
    check(b1, b0);
    check(pace, b0);
    mode_sw <= 1'b0;
    // Night period lowers the basic rate
    bus_write(4'h0, ctrl(1'b0, 1'b0, 1'b1, 2'h3, 4'hA));
    cardiac_event_model_i.beat(2'h2);
    get_field(4'hC, b0);
    check(b0, 32'h1F4);
    note("mode and night");
    // Automatic gain: a high day lowers, a low week raises
    bus_write(4'h0, ctrl(1'b1, 1'b1, 1'b0, 2'h3, 4'hA));
    ampl <= 8'hFF;
    repeat (9) cardiac_event_model_i.beat(2'h0);
    check(rec, 32'h514);
    r = 32'h4;
    while (r[3:0] === 4'h4)
      bus_read(4'h8, r);
    check(r[3:0], 32'h3);
    ampl <= 8'h00;
    // Enough beats to fall below the high mark before the next day
    repeat (15) cardiac_event_model_i.beat(2'h0);
    r = 32'h3;
    while (r[3:0] === 4'h3)
      bus_read(4'h8, r);
    check(r[3:0], 32'h4);
    note("auto gain");
    end_sim();
  end
endmodule : pacing_rate_fading_control_tb

/* rate_fading_consts.svh */
// Constants for the pacing rate fading governor
`ifndef RATE_FADING_CONSTS_SVH
`define RATE_FADING_CONSTS_SVH
// Register byte offsets
`define RF_CTRL_OFS 4'h0
`define RF_RATES_OFS 4'h4
`define RF_SENS_OFS 4'h8
`define RF_NIGHT_OFS 4'hC
`define RF_STAT_OFS 4'h0
// Control field positions
`define RF_CTRL_RA 0
`define RF_CTRL_AG 1
`define RF_CTRL_STAB 2
`define RF_CTRL_NIGHT 3
`define RF_CTRL_DEC_LO 4
`define RF_CTRL_INC_LO 8
// Reset values, rates in 0.1 bpm
`define RF_BASIC_RST 11'h258
`define RF_NIGHT_RST 11'h1F4
`define RF_MSR_RST 11'h514
`define RF_GAIN_RST 4'h4
`define RF_THR_RST 4'h2
`define RF_INC_RST 4'h2
// Fixed figures
`define RF_RUN_LEN 3'h4
`define RF_OFFSET_10BPM 11'h064
`define RF_HIGH_SECONDS 32'h0000005A
`define RF_GAIN_MAX 4'hF
`define RF_THR_MAX 4'hF
`define RF_WEEK_DAYS 3'h7
`define RF_CLK_HZ 32'h02FAF080
`endif

/* rate_fading_pkg.sv */
// Types for the pacing rate fading governor
package rate_fading_pkg;
  typedef logic [10:0] rate_t;
  typedef enum logic [1:0] {
    DEC_01 = 2'h0,
    DEC_02 = 2'h1,
    DEC_05 = 2'h2,
    DEC_10 = 2'h3
  } dec_step_t;
endpackage : rate_fading_pkg
